// [verilog/otwc_top.sv]
// overtemperature warning comparator with 100 ms debounce
// assumes adc sample inputs and register writes are synchronous to mclk
//
// Summary of operation
// - threshold is zero above eight programmed bits
// - compare only top nine adc result bits
// - warning when truncated result below threshold
// - warning flag debounced over 100 ms
// - one threshold step is 3.125 mV
`timescale 1ns/1ps
`default_nettype none

module otwc_top #(
  parameter int ADC_W        = otwc_pkg::ADC_W,
  parameter int DEBOUNCE_CYC = otwc_pkg::DEBOUNCE_CYC
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // register port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  // temp_sensor_adc result
  input  wire logic [ADC_W-1:0]  adc_result,
  input  wire logic              adc_valid,
  // status
  output logic                   warn_flag
);

  // counter width holds the whole debounce count
  localparam int               CNT_W    = $clog2(DEBOUNCE_CYC + 1);
  // last counter code; one interval runs from zero up to this code
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE_CYC - 1);

  // widen a programmed code to the compare width
  // the fixed zero on top keeps the threshold in the lower half,
  // so a reading with its top bit set can never count as below
  function automatic logic [8:0] otwc_ext9(input logic [7:0] code);
    return {1'b0, code};
  endfunction

  // state
  logic [7:0]       thresh_ff;      // warning_threshold_field
  logic [7:0]       rdata_ff;       // read data holder
  logic             raw_ff;         // last compare result
  logic             warn_ff;        // debounced flag
  logic [CNT_W-1:0] cnt_ff;         // stability counter

  // decode
  // one address compare serves both the write and the read path
  wire              sel_thresh = (reg_addr == otwc_pkg::THRESH_OFFSET);
  // threshold as the comparator sees it
  wire [8:0]        thresh9    = otwc_ext9(thresh_ff);
  // only the top nine result bits matter; lower bits dropped on purpose
  wire [8:0]        adc_top9   = adc_result[ADC_W-1 -: 9];
  // strict compare: a reading equal to the threshold does not warn
  wire              below      = (adc_top9 < thresh9);
  // raw holds between samples; counter restarts on any change
  wire              nxt_raw    = adc_valid ? below : raw_ff;
  // the raw compare moves at this edge
  wire              changed    = (nxt_raw != raw_ff);
  // flag and raw agree, nothing left to debounce
  wire              settled    = (raw_ff == warn_ff);
  // counter has reached the end of a full interval
  wire              stable_end = (cnt_ff == CNT_LAST);
  // a step is STEP_UV microvolts; field code maps linearly no scaling needed in logic
  // the host turns a voltage into a code, so the logic never converts units

  // threshold register; codes outside 0x03..0xfa are the writer's problem
  // storing them anyway keeps the register a plain read-back of the write
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      thresh_ff <= otwc_pkg::THRESH_RESET;
    end else if (reg_wr && sel_thresh) begin
      thresh_ff <= reg_wdata;
    end
  end

  // read path, unmapped reads return zero
  // read data is registered so the output comes straight from a flip-flop
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= sel_thresh ? thresh_ff : 8'h00;
    end
  end

  // debounce: flag follows raw only after DEBOUNCE_CYC stable cycles
  // a restart on every change keeps a chattering reading from setting the flag;
  // the price is that a reading hovering at the threshold may never warn
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      raw_ff  <= 1'b0;
      cnt_ff  <= '0;
      warn_ff <= 1'b0;
    end else begin
      raw_ff <= nxt_raw;
      if (changed || settled) begin
        // fresh change or nothing pending: start over
        cnt_ff <= '0;
      end else if (stable_end) begin
        // full interval held: report the new level
        warn_ff <= raw_ff;
        cnt_ff  <= '0;
      end else begin
        // still inside the interval
        cnt_ff <= cnt_ff + CNT_W'(1);
      end
    end
  end

  // outputs straight from their flip-flops
  assign reg_rdata = rdata_ff;
  assign warn_flag = warn_ff;

  // checks: debounce timing
  // the flag may only move at the end of an unbroken interval
  a_flag_needs_stable: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(warn_ff) |-> $past(stable_end) && !$past(changed))
    else $error("flag moved without full stable interval");
  // the flag takes the level that was held, never its inverse
  a_flag_matches_raw: assert property (@(posedge mclk) disable iff (sys_rst)
    $changed(warn_ff) |-> warn_ff == $past(raw_ff))
    else $error("flag took wrong value");
  // a restart clears the counter at the next edge
  a_cnt_restart: assert property (@(posedge mclk) disable iff (sys_rst)
    changed |=> cnt_ff == '0)
    else $error("counter not restarted");
  // with nothing pending the counter stays at zero
  a_idle_no_count: assert property (@(posedge mclk) disable iff (sys_rst)
    settled |=> cnt_ff == '0)
    else $error("counter ran while settled");
  // the counter never passes its last code
  a_cnt_bounded: assert property (@(posedge mclk) disable iff (sys_rst)
    cnt_ff <= CNT_LAST)
    else $error("counter overran interval");

  // checks: comparator
  // a reading in the upper half is never below the threshold
  a_cmp_msb_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (adc_top9[8] && adc_valid) |=> !raw_ff)
    else $error("upper half reading flagged below");
  // strict less-than against the widened threshold
  a_cmp_strict: assert property (@(posedge mclk) disable iff (sys_rst)
    adc_valid |=> raw_ff == ($past(adc_top9) < otwc_ext9($past(thresh_ff))))
    else $error("compare result wrong");
  // equal top bits never warn, whatever the low bits hold
  a_lsb_ignored: assert property (@(posedge mclk) disable iff (sys_rst)
    adc_valid && adc_top9 == thresh9 |=> !raw_ff)
    else $error("low bits affected compare");
  // without a new sample the compare result is kept
  a_hold_raw: assert property (@(posedge mclk) disable iff (sys_rst)
    !adc_valid |=> raw_ff == $past(raw_ff))
    else $error("compare moved without sample");

  // checks: register port
  // a write to the threshold lands at the next edge
  a_wr_stores: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_wr && sel_thresh |=> thresh_ff == $past(reg_wdata))
    else $error("threshold write lost");
  // writes elsewhere leave the threshold alone
  a_wr_other_kept: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_wr && !sel_thresh |=> $stable(thresh_ff))
    else $error("stray write changed threshold");
  // read-back of the stored code
  a_rd_data: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_rd && sel_thresh |=> reg_rdata == $past(thresh_ff))
    else $error("read data wrong");
  // unmapped reads return zero
  a_rd_unmapped: assert property (@(posedge mclk) disable iff (sys_rst)
    reg_rd && !sel_thresh |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // reset leaves the flag low and the threshold at its reset code
  a_reset_state: assert property (@(posedge mclk)
    sys_rst |=> !warn_ff && reg_rdata == 8'h00 && thresh_ff == otwc_pkg::THRESH_RESET)
    else $error("reset state wrong");

  // covers for the main scenarios
  c_warn_set:   cover property (@(posedge mclk) $rose(warn_ff));
  c_warn_clear: cover property (@(posedge mclk) $fell(warn_ff));
  c_glitch:     cover property (@(posedge mclk) changed ##1 changed);
  c_hold:       cover property (@(posedge mclk) !adc_valid && raw_ff);
endmodule // otwc_top

`default_nettype wire

// [verilog/otwc_pkg.sv]
// package for the overtemperature warning comparator
// assumes a single 100 MHz clock and a synchronous active-high reset
package otwc_pkg;
  // register map
  localparam logic [15:0] THRESH_OFFSET   = 16'hfe1a; // warning threshold register
  localparam logic [7:0]  THRESH_RESET    = 8'h00;    // threshold after reset
  localparam int          THRESH_W        = 8;        // programmed field width
  localparam int          CMP_W           = 9;        // compare width
  // allowed codes for software
  localparam logic [7:0]  THRESH_MIN_CODE = 8'h03;
  localparam logic [7:0]  THRESH_MAX_CODE = 8'hfa;
  // one step is 3.125 mV, written in microvolts
  localparam int          STEP_UV         = 3125;
  // debounce time
  localparam int          CLK_HZ          = 100_000_000;
  localparam int          DEBOUNCE_MS     = 100;
  localparam int          DEBOUNCE_CYC    = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int          ADC_W           = 12;       // default sensor result width
endpackage

// [testbench/otwc_adc_model.sv]
// adc stand-in for the bench
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
module otwc_adc_model (
  input  wire logic [11:0] want,
  input  wire logic        strobe,
  output logic      [11:0] adc_result,
  output logic             adc_valid
);
  assign adc_result = want;
  assign adc_valid  = strobe; // low holds the last sample
endmodule // otwc_adc_model
`default_nettype wire

// [testbench/tb_top.sv]
// bench for register port and flag timing
// assumes debounce cut to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [15:0] OFF = otwc_pkg::THRESH_OFFSET;
  logic        mclk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, adc_valid, warn_flag;
  logic [7:0]  reg_wdata = 8'h00, t, reg_rdata;
  logic [11:0] want = 12'hfff, adc_result; // asked reading
  logic [15:0] reg_addr = 16'h0000;
  logic        strobe = 1'b1; // sample strobe of the adc stand-in
  logic [31:0] s = 32'h0000004a;
  int          n_errors = 0, total_checks = 0;
  always #5 mclk = ~mclk;
  otwc_adc_model i_otwc_adc_model (.want(want), .strobe(strobe), .adc_result(adc_result),
    .adc_valid(adc_valid));
  otwc_top #(.ADC_W(12), .DEBOUNCE_CYC(20)) i_otwc_top (.mclk(mclk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .adc_result(adc_result), .adc_valid(adc_valid), .warn_flag(warn_flag));
  function automatic logic [31:0] xs();
    s ^= s << 13; s ^= s >> 17; s ^= s << 5; return s;
  endfunction
  task automatic cyc(int n); repeat (n) @(posedge mclk); #1; endtask
  task automatic wrrd(logic w, logic [15:0] a, logic [7:0] d, logic [7:0] e);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, 1'b0, a, d}; cyc(1);
    {reg_wr, reg_rd} = 2'b01; cyc(1);
    reg_rd = 1'b0; cyc(1); chk(reg_rdata, e);
  endtask
  task automatic chk(logic [7:0] g, logic [7:0] e);
    total_checks++;
    if (g !== e) begin n_errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end
  endtask
  task automatic run(logic [8:0] v, logic e, logic g, logic h);
    want = {v, 3'(xs())};
    if (g) begin cyc(10); want = 12'hfff; cyc(1); want = {v, 3'h0}; end
    cyc(15); chk({7'h00, warn_flag}, 8'h00);
    if (h) begin strobe = 1'b0; want = 12'hfff; cyc(3); want = {v, 3'h0}; strobe = 1'b1; cyc(7); end
    else cyc(10);
    chk({7'h00, warn_flag}, {7'h00, e});
    want = 12'hfff; cyc(25);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    cyc(6); sys_rst = 1'b0;
    wrrd(1'b0, OFF, 8'h00, otwc_pkg::THRESH_RESET);
    wrrd(1'b1, OFF + 16'h0001, 8'h55, 8'h00); // unmapped
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      t = (i == 0) ? 8'h03 : (i == 1) ? 8'hfa : 8'h03 + 8'(xs() % 248);
      wrrd(1'b1, OFF, t, t);
      run({1'b0, t} - 9'h001, 1'b1, i == 2, i == 3);
      run({1'b0, t}, 1'b0, 1'b0, 1'b0);
      run({1'b1, 8'(xs())}, 1'b0, 1'b0, 1'b0);
    end
    $display("test compare done"); tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
